// File: design/hyp_ctl_pkg.sv
// Shared constants and carriers for the hypervisor fence and status control block
package hyp_ctl_pkg;
	localparam int XLEN_MAX = 64;

	// Privilege encodings
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;

	// Machine status field positions
	localparam int POS_UIE = 0;
	localparam int POS_SIE = 1;
	localparam int POS_UPIE = 4;
	localparam int POS_SPIE = 5;
	localparam int POS_MPIE = 7;
	localparam int POS_MIE = 3;
	localparam int POS_SPP = 8;
	localparam int POS_MPP = 11;
	localparam int POS_FS = 13;
	localparam int POS_XS = 15;
	localparam int POS_MODIFY_PRIVILEGE = 17;
	localparam int POS_SUM = 18;
	localparam int POS_MXR = 19;
	localparam int POS_TVM = 20;
	localparam int POS_TW = 21;
	localparam int POS_TSR = 22;
	localparam int POS_UXL = 32;
	localparam int POS_SXL = 34;
	localparam int POS_MTL = 38;
	localparam int POS_MPV = 39;
	localparam int POS_SD = 63;

	// Writable bits of machine status; foreground supervisor status view
	localparam logic [63:0] MSTATUS_WMASK = 64'h0000_00CF_007F_F9BB;
	localparam logic [63:0] SSTATUS_MASK = 64'h8000_0003_000D_E133;
	localparam logic [63:0] MSTATUS_RESET = 64'h0000_000A_0000_0000;
	localparam logic [63:0] RV32_HIDE_MASK = 64'h0000_00C0_0000_0000;

	// Width field encoding for 32-bit
	localparam logic [1:0] WIDTH_32 = 2'h1;

	// Fence instruction encoding
	localparam logic [6:0] OPC_SYSTEM = 7'h73;
	localparam logic [2:0] F3_PRIV = 3'h0;
	localparam logic [6:0] F7_GUEST_FENCE = 7'h51;
	localparam logic [6:0] F7_VS_FENCE = 7'h11;
	localparam logic [4:0] REG_ZERO = 5'h00;

	typedef enum logic [1:0]
	{
		FENCE_NONE = 2'b00,
		FENCE_GUEST = 2'b01,
		FENCE_VS = 2'b10
	} fence_kind_e;

	// Request to translation logic to flush structures
	typedef struct packed
	{
		logic        valid;
		logic        guest_phys;     // Guest-physical structures
		logic        vs_level;       // Background VS-level structures
		logic        all_addr;
		logic        all_id;
		logic [63:0] addr;
		logic [15:0] id;
		logic [15:0] vmid;
	} fence_req_s;

	// Effective access mode for loads and stores
	typedef struct packed
	{
		logic [1:0] priv;
		logic       virt;
		logic       bare;
		logic       two_level;
		logic       hs_mxr;
		logic       vs_mxr;
		logic       sum;
	} eff_mode_s;
endpackage : hyp_ctl_pkg

// File: design/hyp_fence_and_mstatus_ctl.sv
// Hypervisor fence decode, machine status extension and effective mode logic
//
// Overview of operation
// (RULE1) Fences legal in machine, or HS without trap_virtual_memory
// (RULE2) Illegal fence raises illegal-instruction exception
// (RULE3) Guest fence hits guest table; VS fence background
// (RULE4) Supervisor fence touches foreground structures only
// (RULE5) VS fence ordering scoped to current VM id
// (RULE6) VS fence: nonzero rs1 address, rs2 identifier
// (RULE7) VS fence ignores identifier bits above implemented width
// (RULE8) VS fence may go global over everything
// (RULE9) Guest fence orders stores before guest-physical reads
// (RULE10) Guest fence: rs1 address>>2, rs2 VM identifier
// (RULE11) 32-bit: rs1 holds guest address bits 33:2
// (RULE12) Guest fence ignores VM id bits above width
// (RULE13) Guest fence may go global over everything
// (RULE14) Machine trap saves virtualization into prev_virt_bit
// (RULE15) Machine return restores virtualization unless privilege 3
// (RULE16) Machine trap sets fault_translation_level for guest faults
// (RULE17) 32-bit harts hide prev_virt and translation-level bits
// (RULE18) Supervisor width for HS, user width otherwise; machine mode gets fixed 2'h2 (WIDTH_32 on 32-bit), VS mode gets bg_uxl (WIDTH_32 on 32-bit)
// (RULE19) Return and memory traps only apply in HS
// (RULE20) Timeout wait applies in all non-machine modes
// (RULE21) Modify-privilege uses saved privilege and virtualization
// (RULE22) Saved privilege 3 gives untranslated machine access
// (RULE23) Virtualized previous mode uses two-level translation rules
// (RULE24) Hypervisor modify-privilege substitutes hypervisor saved fields
// (RULE25) Supervisor status is a view of machine status
// (RULE26) VS width from background status, else foreground
// (RULE27) Virtualization change swaps translation control registers
`timescale 1ns/1ps

module hyp_fence_and_mstatus_ctl
#(
	parameter int  ASID_LEN  = 16,      // Implemented guest address-space id width
	parameter int  VMID_LEN  = 14,      // Implemented VM id width
	parameter bit  IS_RV32   = 1'b0,    // 32-bit hart
	parameter bit  GLOBAL_FENCE = 1'b0  // Simple flush-everything fences
)
(
	input  wire logic                    sys_clk,         // Hart clock
	input  wire logic                    nrst,            // Async reset, active low
	// Instruction issue
	input  wire logic                    insn_valid,      // Instruction presented
	input  wire logic [31:0]             insn,            // Instruction word
	input  wire logic [63:0]             rs1_val,         // First source value
	input  wire logic [63:0]             rs2_val,         // Second source value
	input  wire logic [1:0]              cur_priv,        // Current privilege
	input  wire logic [15:0]             cur_vmid,        // Guest translation VM id
	output logic                         illegal_insn,    // Illegal-instruction exception
	output hyp_ctl_pkg::fence_req_s      fence_req,       // Flush request, registered
	// Traps and returns
	input  wire logic                    trap_to_m,       // Trap taken into machine mode
	input  wire logic                    trap_guest_fault, // Fault from guest translation
	input  wire logic                    machine_return,  // Machine return executed
	input  wire logic                    virt_set,        // Other virtualization change
	input  wire logic                    virt_set_val,    // Value for that change
	output logic                         virt,            // Current virtualization mode
	output logic                         swap_satp,       // Swap background/foreground tables
	// Status register access
	input  wire logic                    mstatus_we,      // Machine status write
	input  wire logic                    sstatus_we,      // Supervisor status write
	input  wire logic [63:0]             csr_wdata,       // Write data
	output logic [63:0]                  machine_status,  // Machine status read
	output logic [63:0]                  sstatus_rdata,   // Foreground supervisor status
	input  wire logic [1:0]              bg_uxl,          // Background status user width
	// Hypervisor status inputs
	input  wire logic                    hyp_modify_privilege, // Hypervisor modify-privilege
	input  wire logic                    hyp_saved_virt_bit,   // Hypervisor saved virt
	input  wire logic                    hs_saved_supervisor_privilege, // HS saved privilege
	input  wire logic                    hs_mxr,          // HS-level exec-readable
	input  wire logic                    vs_mxr,          // VS-level exec-readable
	input  wire logic                    vs_sum,          // VS-level user access
	// Derived controls
	output logic [1:0]                   cur_xlen_field,  // Width code for current mode
	output logic                         tsr_active,      // Return trap in effect
	output logic                         tvm_active,      // Memory trap in effect
	output logic                         tw_active,       // Timeout wait in effect
	output hyp_ctl_pkg::eff_mode_s       eff_mode         // Load/store effective mode
);
	import hyp_ctl_pkg::*;

	logic [63:0] status;
	logic        virt_q;
	logic [63:0] vis_mask;

	// Decode
	wire         is_sys = insn[6:0] == OPC_SYSTEM && insn[14:12] == F3_PRIV
		&& insn[11:7] == REG_ZERO;
	wire         dec_guest = is_sys && insn[31:25] == F7_GUEST_FENCE;
	wire         dec_vs = is_sys && insn[31:25] == F7_VS_FENCE;
	wire         is_fence = insn_valid && (dec_guest || dec_vs);
	wire [4:0]   rs1_idx = insn[19:15];
	wire [4:0]   rs2_idx = insn[24:20];
	wire         hs_mode = cur_priv == PRIV_S && !virt_q;
	wire         in_m = cur_priv == PRIV_M;
	wire         fence_ok = in_m || (hs_mode && !status[POS_TVM]); // RULE1
	wire         next_fence_go = is_fence && fence_ok;

	// Identifier field masks; upper bits dropped
	wire [15:0]  asid_mask = 16'(({16'h0000, 16'hffff} >> (16 - ASID_LEN))); // RULE7
	wire [15:0]  vmid_mask = 16'(({16'h0000, 16'hffff} >> (16 - VMID_LEN))); // RULE12
	// Guest address: rs1 carries address >> 2
	wire [63:0]  guest_addr = IS_RV32 ? {30'h0000_0000, rs1_val[31:0], 2'b00} // RULE11
		: {rs1_val[61:0], 2'b00}; // RULE10
	wire [63:0]  vs_addr = rs1_val; // RULE6

	assign illegal_insn = is_fence && !fence_ok; // RULE2

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			fence_req <= '0;
		else
		begin
			fence_req.valid      <= next_fence_go; // RULE9
			// Guest fence never touches VS structures and vice versa, unless GLOBAL_FENCE sets both
			fence_req.guest_phys <= dec_guest || GLOBAL_FENCE; // RULE3
			fence_req.vs_level   <= dec_vs || GLOBAL_FENCE; // RULE4
			fence_req.all_addr   <= rs1_idx == REG_ZERO || GLOBAL_FENCE; // RULE8
			fence_req.all_id     <= rs2_idx == REG_ZERO || GLOBAL_FENCE; // RULE13
			fence_req.addr       <= dec_guest ? guest_addr : vs_addr;
			fence_req.id         <= dec_guest ? (rs2_val[15:0] & vmid_mask)
				: (rs2_val[15:0] & asid_mask);
			// VS fence scoped to the VM live at fence time
			fence_req.vmid       <= cur_vmid & vmid_mask; // RULE5
		end
	end

	// Machine status
	wire [1:0]   saved_prev_privilege = status[POS_MPP+:2];
	wire         prev_virt_bit = status[POS_MPV];
	wire [63:0]  mstatus_wr = (status & ~MSTATUS_WMASK) | (csr_wdata & MSTATUS_WMASK);
	wire [63:0]  sstatus_wr = (status & ~SSTATUS_MASK) | (csr_wdata & SSTATUS_MASK);
	logic [63:0] next_status;
	logic        next_virt;

	always_comb
	begin
		next_status = status;
		next_virt = virt_q;
		if (trap_to_m)
		begin
			next_status[POS_MPV] = virt_q; // RULE14
			next_status[POS_MTL] = trap_guest_fault; // RULE16
			next_status[POS_MPP+:2] = cur_priv;
			next_status[POS_MPIE] = status[POS_MIE];
			next_status[POS_MIE] = 1'b0;
			next_virt = 1'b0;
		end
		else if (machine_return)
		begin
			next_virt = (saved_prev_privilege == PRIV_M) ? 1'b0 : prev_virt_bit; // RULE15
			next_status[POS_MIE] = status[POS_MPIE];
			next_status[POS_MPIE] = 1'b1;
			next_status[POS_MPP+:2] = PRIV_U;
		end
		else if (mstatus_we)
			next_status = mstatus_wr;
		else if (sstatus_we)
			next_status = sstatus_wr; // RULE25
		else if (virt_set)
			next_virt = virt_set_val;
		if (IS_RV32)
			next_status = next_status & ~RV32_HIDE_MASK; // RULE17
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			status <= MSTATUS_RESET;
			virt_q <= 1'b0;
			swap_satp <= 1'b0;
		end
		else
		begin
			status <= next_status;
			virt_q <= next_virt;
			swap_satp <= next_virt != virt_q; // RULE27
		end
	end

	// Both views read the same storage
	assign vis_mask = IS_RV32 ? ~RV32_HIDE_MASK : 64'hffff_ffff_ffff_ffff;
	assign machine_status = status & vis_mask;
	assign sstatus_rdata = status & SSTATUS_MASK; // RULE25
	assign virt = virt_q;

	// Width per mode
	wire [1:0]   supervisor_width_field = IS_RV32 ? WIDTH_32 : status[POS_SXL+:2];
	wire [1:0]   user_width_field = IS_RV32 ? WIDTH_32 : status[POS_UXL+:2];
	wire         vs_mode = cur_priv == PRIV_S && virt_q;
	assign cur_xlen_field = in_m ? (IS_RV32 ? WIDTH_32 : 2'h2)
		: hs_mode ? supervisor_width_field // RULE18
		: vs_mode ? (IS_RV32 ? WIDTH_32 : bg_uxl) // RULE26
		: user_width_field;

	assign tsr_active = hs_mode && status[POS_TSR]; // RULE19
	assign tvm_active = hs_mode && status[POS_TVM]; // RULE19
	assign tw_active = !in_m && status[POS_TW]; // RULE20

	// Effective access mode
	wire         modify_privilege = status[POS_MODIFY_PRIVILEGE];
	wire         use_hyp = modify_privilege && saved_prev_privilege != PRIV_M && hyp_modify_privilege; // RULE24
	wire [1:0]   sel_priv = use_hyp ? {1'b0, hs_saved_supervisor_privilege}
		: modify_privilege ? saved_prev_privilege : cur_priv; // RULE21
	wire         sel_virt = use_hyp ? hyp_saved_virt_bit
		: modify_privilege ? (saved_prev_privilege != PRIV_M && prev_virt_bit) : virt_q;
	wire         m_level = sel_priv == PRIV_M; // RULE22

	always_comb
	begin
		eff_mode.priv = sel_priv;
		eff_mode.virt = sel_virt && !m_level;
		eff_mode.bare = m_level;
		eff_mode.two_level = sel_virt && !m_level; // RULE23
		eff_mode.hs_mxr = hs_mxr;
		eff_mode.vs_mxr = sel_virt && vs_mxr;
		eff_mode.sum = sel_virt ? vs_sum : status[POS_SUM]; // RULE23
	end
endmodule : hyp_fence_and_mstatus_ctl

// File: tb/hyp_ctl_monitor.sv
// Port checker for the hypervisor fence and status block
`timescale 1ns/1ps
module hyp_ctl_monitor
(
	input  wire logic             sys_clk,          // Clock
	input  wire logic             nrst,             // Reset
	input  wire logic             insn_valid,       // Issue
	input  wire logic [31:0]      insn,             // Word
	input  wire logic [63:0]      rs1_val,          // Operand
	input  wire logic [1:0]       cur_priv,         // Mode
	input  wire logic             illegal_insn,     // Refusal
	input  hyp_ctl_pkg::fence_req_s fence_req,      // Flush
	input  wire logic             trap_to_m,        // Trap
	input  wire logic             trap_guest_fault, // Guest fault
	input  wire logic             machine_return,   // Return
	input  wire logic             virt,             // Mode V
	input  wire logic             swap_satp,        // Swap
	input  wire logic [63:0]      machine_status,   // Status
	input  wire logic [63:0]      sstatus_rdata,    // View
	input  wire logic             tw_active,        // Wait trap
	input  wire logic             tvm_active,       // VM trap
	input  hyp_ctl_pkg::eff_mode_s eff_mode         // Access mode
);
	import hyp_ctl_pkg::*;
	wire fz = insn_valid && insn[6:0] == OPC_SYSTEM && insn[14:12] == F3_PRIV
		&& insn[11:7] == REG_ZERO;
	wire gf = fz && insn[31:25] == F7_GUEST_FENCE;
	wire vf = fz && insn[31:25] == F7_VS_FENCE;
	wire ret_v = machine_status[POS_MPV] && machine_status[12:11] != PRIV_M;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_FENCE_OK: assert property (
		(gf || vf) && cur_priv == PRIV_M |-> !illegal_insn
		##1 fence_req.valid && fence_req.guest_phys == $past(gf)) else $error("fence lost");
	AST_FENCE_BAD: assert property (
		(gf || vf) && cur_priv == PRIV_U |-> illegal_insn ##1 !fence_req.valid)
		else $error("user fence accepted");
	AST_GADDR: assert property (
		gf && cur_priv == PRIV_M && insn[19:15] != REG_ZERO
		|=> fence_req.addr == $past(rs1_val) << 2) else $error("guest address wrong");
	AST_TRAP: assert property (
		trap_to_m |=> machine_status[POS_MPV] == $past(virt) && !virt
		&& machine_status[POS_MTL] == $past(trap_guest_fault)) else $error("trap save wrong");
	AST_MACHINE_RETURN: assert property (
		machine_return && !trap_to_m |=> virt == $past(ret_v)) else $error("return mode wrong");
	AST_SWAP: assert property (
		swap_satp == $changed(virt)) else $error("table swap not with mode change");
	AST_TW: assert property (
		tw_active == (cur_priv != PRIV_M && machine_status[POS_TW])) else $error("wait trap wrong");
	AST_TVM: assert property (
		tvm_active == (cur_priv == PRIV_S && !virt && machine_status[POS_TVM]))
		else $error("vm trap wrong");
	AST_SVIEW: assert property (
		sstatus_rdata == (machine_status & SSTATUS_MASK)) else $error("status view wrong");
	AST_MODIFY_PRIVILEGE_M: assert property (
		machine_status[POS_MODIFY_PRIVILEGE] && machine_status[12:11] == PRIV_M
		|-> eff_mode.bare && eff_mode.priv == PRIV_M) else $error("machine access wrong");
	cover property (gf && cur_priv == PRIV_S);
	cover property (trap_to_m && trap_guest_fault);
	cover property (machine_return && ret_v);
endmodule : hyp_ctl_monitor

bind hyp_fence_and_mstatus_ctl hyp_ctl_monitor i_hyp_ctl_monitor (.sys_clk, .nrst, .insn_valid,
	.insn, .rs1_val, .cur_priv, .illegal_insn, .fence_req, .trap_to_m, .trap_guest_fault,
	.machine_return,
	.virt, .swap_satp, .machine_status, .sstatus_rdata, .tw_active, .tvm_active, .eff_mode);

// File: tb/hyp_far_side.sv
// Translation-side model that takes flush requests
`timescale 1ns/1ps
module hyp_far_side
(
	input  wire logic               sys_clk,   // Clock
	input  wire logic               nrst,      // Reset
	input  hyp_ctl_pkg::fence_req_s fence_req, // Flush
	output int                      flush_cnt  // Flushes done
);
	import hyp_ctl_pkg::*;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			flush_cnt <= 0;
		else if (fence_req.valid)
			flush_cnt <= flush_cnt + 1;
endmodule : hyp_far_side

// File: tb/tb_top.sv
// Self-checking bench for the hypervisor fence and status block
`timescale 1ns/1ps
module tb_top;
	import hyp_ctl_pkg::*;
	localparam int ASID_L = 12;
	logic        sys_clk = 0, nrst = 0, insn_valid = 0, trap_to_m = 0, trap_guest_fault = 0;
	logic        machine_return = 0, virt_set = 0, virt_set_val = 0;
	logic        mstatus_we = 0, sstatus_we = 0;
	logic        hyp_modify_privilege = 0, hyp_saved_virt_bit = 0;
	logic        hs_saved_supervisor_privilege = 0, hs_mxr = 0, vs_mxr = 0, vs_sum = 0;
	logic [31:0] insn = '0;
	logic [63:0] rs1_val = '0, rs2_val = '0, csr_wdata = '0;
	logic [1:0]  cur_priv = 2'h3, bg_uxl = 2'h0;
	logic [15:0] cur_vmid = '0;
	logic        illegal_insn, virt, swap_satp, tsr_active, tvm_active, tw_active;
	logic [63:0] machine_status, sstatus_rdata;
	logic [1:0]  cur_xlen_field;
	fence_req_s  fence_req;
	eff_mode_s   eff_mode;
	int          error_cnt = 0, num_checks = 0, flush_cnt, exp_flush = 0;

	hyp_fence_and_mstatus_ctl #(.ASID_LEN(ASID_L), .VMID_LEN(10)) i_hyp_fence_and_mstatus_ctl (.*);
	hyp_far_side i_hyp_far_side (.*);

	always #2.5 sys_clk = ~sys_clk;
	// Side inputs wander so the mode logic never sees one fixed pattern
	always @(posedge sys_clk)
		{hyp_modify_privilege, hyp_saved_virt_bit, hs_saved_supervisor_privilege, hs_mxr, vs_mxr,
			vs_sum, cur_vmid} <= 22'($urandom);

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop();
		if (error_cnt == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	function automatic bit fence_ok(input logic [1:0] p, input bit trap_virtual_memory);
		return p == PRIV_M || (p == PRIV_S && !trap_virtual_memory);
	endfunction : fence_ok

	task automatic wr(input bit sup, input logic [63:0] v);
		@(posedge sys_clk);
		mstatus_we <= !sup;
		sstatus_we <= sup;
		csr_wdata <= v;
		@(posedge sys_clk);
		mstatus_we <= 0;
		sstatus_we <= 0;
		#1;
	endtask : wr

	task automatic fence(input bit g, input logic [1:0] p, input bit trap_virtual_memory);
		logic [4:0]  r1;
		logic [63:0] a, b;
		bit          ok;
		r1 = ($urandom % 2) ? 5'($urandom | 1) : REG_ZERO;
		a = {$urandom, $urandom};
		b = 64'($urandom) & (g ? 64'h0000_0000_0000_3fff : 64'h0000_0000_0000_ffff);
		ok = fence_ok(p, trap_virtual_memory);
		@(posedge sys_clk);
		insn_valid <= 1;
		insn <= {g ? F7_GUEST_FENCE : F7_VS_FENCE, 5'h2, r1, F3_PRIV, REG_ZERO, OPC_SYSTEM};
		rs1_val <= a;
		rs2_val <= b;
		cur_priv <= p;
		#1 chk(illegal_insn, !ok);
		@(posedge sys_clk);
		insn_valid <= 0;
		#1 chk(fence_req.valid, ok);
		exp_flush += ok;
		if (ok)
		begin
			chk({fence_req.guest_phys, fence_req.vs_level}, {g, !g});
			chk(fence_req.all_addr, r1 == REG_ZERO);
			if (r1 != REG_ZERO) chk(fence_req.addr, g ? a << 2 : a);
			if (!g) chk(fence_req.id, b & ((64'h1 << ASID_L) - 1));
		end
	endtask : fence

	task automatic trap_ret(input logic [1:0] p, input bit v_back);
		bit gf;
		gf = 1'($urandom);
		@(posedge sys_clk);
		trap_to_m <= 1;
		trap_guest_fault <= gf;
		cur_priv <= p;
		@(posedge sys_clk);
		trap_to_m <= 0;
		#1 chk({machine_status[POS_MPV], machine_status[POS_MTL], virt}, {1'b1, gf, 1'b0});
		@(posedge sys_clk);
		machine_return <= 1;
		@(posedge sys_clk);
		machine_return <= 0;
		#1 chk(virt, v_back);
	endtask : trap_ret

	initial
	begin
		void'($urandom(87));
		repeat (20) @(posedge sys_clk);
		nrst <= 1;
		bg_uxl <= 2'($urandom);
		@(posedge sys_clk);
		#1 chk(machine_status, MSTATUS_RESET);
		chk(sstatus_rdata, MSTATUS_RESET & SSTATUS_MASK);
		for (int t = 0; t < 2; t++)
		begin
			wr(0, MSTATUS_RESET | (64'(t) << POS_TVM));
			for (int i = 0; i < 12; i++)
				fence(i[0], (i % 6 < 2) ? PRIV_U : (i % 6 < 4) ? PRIV_S : PRIV_M, t[0]);
		end
		@(posedge sys_clk);
		cur_priv <= PRIV_S;
		virt_set <= 1;
		virt_set_val <= 1;
		#1 chk(cur_xlen_field, 2'h2);
		chk(tvm_active, 1);
		@(posedge sys_clk);
		virt_set <= 0;
		#1 chk(cur_xlen_field, bg_uxl);
		chk(tvm_active, 0);
		chk(swap_satp, 1);
		@(posedge sys_clk);
		#1 chk(swap_satp, 0);
		trap_ret(PRIV_S, 1);
		trap_ret(PRIV_M, 0);
		wr(0, 64'h0000_000A_0022_1800);
		chk(machine_status, 64'h0000_000A_0022_1800);
		chk({eff_mode.bare, eff_mode.priv}, {1'b1, PRIV_M});
		chk(tw_active, 0);
		@(posedge sys_clk);
		cur_priv <= PRIV_U;
		#1 chk(tw_active, 1);
		wr(1, 64'h0000_000A_0004_0000);
		chk({machine_status[POS_SUM], machine_status[POS_MODIFY_PRIVILEGE]}, 2'b11);
		chk(flush_cnt, exp_flush);
		report_and_stop();
	end

	initial
	begin
		repeat (2000) @(posedge sys_clk);
		error_cnt++;
		report_and_stop();
	end
endmodule : tb_top
